// >>> core/watchdog_timer.sv
`default_nettype none
module watchdog_timer #(
  parameter int BASE_CYCLES = watchdog_pkg::BASE_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // register port
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       write_i,
  input  wire logic       read_i,
  output logic      [7:0] rdata_o,
  // configuration and system inputs
  input  wire logic [1:0] hw_watchdog_enable_cfg_i,
  input  wire logic [4:0] watchdog_postscale_select_i,
  input  wire logic       retention_regulator_cfg_i,
  input  wire logic       regulator_enable_pin_i,
  input  wire logic       clear_watchdog_instr_i,
  input  wire logic       sleep_instr_i,
  input  wire logic       sleep_active_i,
  input  wire logic [2:0] internal_osc_freq_select_i,
  input  wire logic       clock_fail_i,
  input  wire logic       ulp_wake_comparator_i,
  // outputs
  output logic            low_freq_internal_osc_en_o,
  output logic            watchdog_reset_o,
  output logic            watchdog_wake_o,
  output logic            regulator_standby_o,
  output logic            regulator_ultra_low_o,
  output logic            ulp_wake_enable_o,
  output logic            ulp_current_sink_o
);
  logic [7:0]  control_reg;
  logic [7:0]  control_next;
  logic [2:0]  freq_sel_reg;
  logic        freq_seen_reg;
  logic [19:0] post_reg;
  logic [19:0] post_next;
  logic        timeout_reg;
  logic        timeout_next;
  logic        reset_pulse_reg;
  logic        wake_pulse_reg;
  logic        level_reg;
  logic [7:0]  rdata_reg;
  logic        tick;

  function automatic logic [19:0] tap_mask(input logic [4:0] sel);
    logic [4:0] s;
    s = (sel > watchdog_pkg::SEL_MAX) ? 5'h0 : sel;
    tap_mask = 20'(({1'b0, 20'hfffff} >> (5'd20 - s)));
  endfunction

  // mode decode
  wire sw_mode = (hw_watchdog_enable_cfg_i == watchdog_pkg::HW_EN_SOFTWARE);
  wire enabled;
  // software bit only in sw mode
  assign enabled =
      (hw_watchdog_enable_cfg_i == watchdog_pkg::HW_EN_ALWAYS) ||
      ((hw_watchdog_enable_cfg_i == watchdog_pkg::HW_EN_RUN_ONLY) && !sleep_active_i) ||
      (sw_mode && control_reg[watchdog_pkg::SW_EN_BIT]);

  assign low_freq_internal_osc_en_o = enabled;

  wire freq_changed = freq_seen_reg && (internal_osc_freq_select_i != freq_sel_reg);
  wire clear_all    = clear_watchdog_instr_i || sleep_instr_i || freq_changed || clock_fail_i;

  watchdog_base_tick #(
    .CYCLES (BASE_CYCLES)
  ) u_base (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   (enabled),
    .clear_i (clear_all),
    .tick_o  (tick)
  );

  // 20 taps from 4 ms span to 2,097 s
  wire [19:0] mask    = tap_mask(watchdog_postscale_select_i);
  wire        expired = tick && ((post_reg & mask) == mask);

  assign post_next = (clear_all || !enabled || expired) ? 20'h0 :
                     tick ? post_reg + 20'h1 : post_reg;

  // time-out status, set wins over clear
  wire status_clear = write_i && (addr_i == watchdog_pkg::STATUS_ADDR) &&
                      wdata_i[watchdog_pkg::TIMEOUT_BIT];
  assign timeout_next = expired ? 1'b1 : (status_clear ? 1'b0 : timeout_reg);

  // register writes
  wire control_write = write_i && (addr_i == watchdog_pkg::CONTROL_ADDR);
  assign control_next = control_write ? (wdata_i & watchdog_pkg::CONTROL_WMASK) : control_reg;

  wire ulp_on = control_reg[watchdog_pkg::ULP_EN_BIT];

  // read mux
  wire [7:0] control_view;
  assign control_view = control_reg | {2'h0, level_reg && ulp_on, 5'h0};
  wire [7:0] status_view = {6'h0, enabled, timeout_reg};
  wire [7:0] read_value  = (addr_i == watchdog_pkg::CONTROL_ADDR) ? control_view :
                           (addr_i == watchdog_pkg::STATUS_ADDR)  ? status_view  : 8'h00;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control_reg     <= watchdog_pkg::CONTROL_RESET;
      freq_sel_reg    <= 3'h0;
      freq_seen_reg   <= 1'b0;
      post_reg        <= 20'h0;
      timeout_reg     <= 1'b0;
      reset_pulse_reg <= 1'b0;
      wake_pulse_reg  <= 1'b0;
      level_reg       <= 1'b0;
      rdata_reg       <= 8'h00;
    end else begin
      control_reg     <= control_next;
      freq_sel_reg    <= internal_osc_freq_select_i;
      freq_seen_reg   <= 1'b1;
      post_reg        <= post_next;
      timeout_reg     <= timeout_next;
      // reset if running, wake if asleep
      reset_pulse_reg <= expired && !sleep_active_i;
      wake_pulse_reg  <= expired && sleep_active_i;
      level_reg       <= ulp_on && ulp_wake_comparator_i;
      rdata_reg       <= read_i ? read_value : 8'h00;
    end
  end

  assign rdata_o          = rdata_reg;
  assign watchdog_reset_o = reset_pulse_reg;
  assign watchdog_wake_o  = wake_pulse_reg;

  assign regulator_standby_o = sleep_active_i && control_reg[watchdog_pkg::REG_SLEEP_BIT];
  assign regulator_ultra_low_o = sleep_active_i && regulator_enable_pin_i &&
                                 !retention_regulator_cfg_i &&
                                 control_reg[watchdog_pkg::RETENTION_BIT];
  assign ulp_wake_enable_o  = ulp_on;
  assign ulp_current_sink_o = ulp_on && control_reg[watchdog_pkg::SINK_BIT];
endmodule
`default_nettype wire

// >>> core/watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;
  // register map (plain port, byte addresses)
  localparam logic [1:0] CONTROL_ADDR    = 2'h0;
  localparam logic [1:0] STATUS_ADDR     = 2'h1;
  // control register fields
  localparam int         SW_EN_BIT       = 0;
  localparam int         SINK_BIT        = 1;
  localparam int         ULP_EN_BIT      = 2;
  localparam int         RETENTION_BIT   = 4;
  localparam int         LEVEL_BIT       = 5;
  localparam int         REG_SLEEP_BIT   = 7;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] CONTROL_WMASK   = 8'h97;
  // status register fields
  localparam int         TIMEOUT_BIT     = 0;
  localparam int         RUNNING_BIT     = 1;
  // hardware enable modes
  localparam logic [1:0] HW_EN_ALWAYS    = 2'h3;
  localparam logic [1:0] HW_EN_SOFTWARE  = 2'h2;
  localparam logic [1:0] HW_EN_RUN_ONLY  = 2'h1;
  localparam logic [1:0] HW_EN_DISABLED  = 2'h0;
  // timing
  localparam int         CLK_HZ          = 50_000_000;
  localparam int         BASE_PERIOD_US  = 4000;
  localparam int         BASE_CYCLES     = CLK_HZ / 1_000_000 * BASE_PERIOD_US;
  localparam int         POST_WIDTH      = 16;
  localparam int         SEL_WIDTH       = 5;
  localparam logic [4:0] SEL_MAX         = 5'h13;
endpackage
`default_nettype wire

// >>> core/watchdog_base_tick.sv
`default_nettype none
// base tick of the low-frequency oscillator domain, one-cycle enable pulse
module watchdog_base_tick #(
  parameter int CYCLES = watchdog_pkg::BASE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  logic [22:0] count_reg;
  logic [22:0] count_next;
  wire         at_end = (count_reg == 23'(CYCLES - 1));

  assign count_next = (clear_i || !run_i || at_end) ? 23'h0 : count_reg + 23'h1;
  assign tick_o     = run_i && !clear_i && at_end;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= 23'h0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// >>> verif/watchdog_timer_asserts.sv
`default_nettype none
module watchdog_timer_asserts (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [1:0] addr_i,
  input wire logic       read_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] hw_watchdog_enable_cfg_i,
  input wire logic       sleep_active_i,
  input wire logic       retention_regulator_cfg_i,
  input wire logic       regulator_enable_pin_i,
  input wire logic       low_freq_internal_osc_en_o,
  input wire logic       watchdog_reset_o,
  input wire logic       regulator_standby_o,
  input wire logic       regulator_ultra_low_o,
  input wire logic       ulp_wake_enable_o,
  input wire logic       ulp_current_sink_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_off; hw_watchdog_enable_cfg_i == 2'h0 |-> !low_freq_internal_osc_en_o; endproperty
  a_off: assert property (p_off) else $error("oscillator on in off mode");
  property p_on; hw_watchdog_enable_cfg_i == 2'h3 |-> low_freq_internal_osc_en_o; endproperty
  a_on: assert property (p_on) else $error("oscillator off in always mode");
  property p_slp;
    hw_watchdog_enable_cfg_i == 2'h1 && sleep_active_i |-> !low_freq_internal_osc_en_o;
  endproperty
  a_slp: assert property (p_slp) else $error("run-only mode on in sleep");
  property p_stby; regulator_standby_o |-> sleep_active_i; endproperty
  a_stby: assert property (p_stby) else $error("standby while awake");
  property p_ulow;
    regulator_ultra_low_o |-> sleep_active_i && regulator_enable_pin_i
                              && !retention_regulator_cfg_i;
  endproperty
  a_ulow: assert property (p_ulow) else $error("ultra low not allowed");
  property p_sink; ulp_current_sink_o |-> ulp_wake_enable_o; endproperty
  a_sink: assert property (p_sink) else $error("sink without wake enable");
  property p_rd; read_i && addr_i == 2'h0 |=> rdata_o[6] == 1'b0 && rdata_o[3] == 1'b0; endproperty
  a_rd: assert property (p_rd) else $error("unused control bits set");
  property p_pulse; watchdog_reset_o |=> !watchdog_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  c_stby: cover property (regulator_standby_o);
  c_ulow: cover property (regulator_ultra_low_o);
  c_sink: cover property (ulp_current_sink_o);
endmodule
bind watchdog_timer watchdog_timer_asserts u_chk (.*);
`default_nettype wire

// >>> verif/watchdog_timer_bench.sv
`default_nettype none
module watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, reset_i, write_i, read_i, retention_regulator_cfg_i, regulator_enable_pin_i;
  logic       clear_watchdog_instr_i, sleep_instr_i, sleep_active_i, clock_fail_i;
  logic       ulp_wake_comparator_i, low_freq_internal_osc_en_o, watchdog_reset_o;
  logic       watchdog_wake_o, regulator_standby_o, regulator_ultra_low_o;
  logic       ulp_wake_enable_o, ulp_current_sink_o;
  logic [1:0] addr_i, hw_watchdog_enable_cfg_i;
  logic [7:0] wdata_i, rdata_o;
  logic [4:0] watchdog_postscale_select_i;
  logic [2:0] internal_osc_freq_select_i;
  logic       exp_on;
  int         bad_count = 0;
  int         n_tests = 0;
  // short base period so time-outs fit the run
  watchdog_timer #(.BASE_CYCLES(8)) uut (.*);
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr_i <= a; wdata_i <= d; write_i <= 1'b1;
    @(posedge clk_i); write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    addr_i <= a; read_i <= 1'b1;
    @(posedge clk_i); read_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clk_i);
  endtask
  // expiry pulse expected exactly n edges after the clearing edge
  task automatic wait_expiry(input int n, input logic asleep);
    repeat (n - 1) @(posedge clk_i);
    #1 chk({6'h0, watchdog_reset_o, watchdog_wake_o}, 8'h00);
    @(posedge clk_i);
    #1 chk({6'h0, watchdog_reset_o, watchdog_wake_o}, asleep ? 8'h01 : 8'h02);
    @(posedge clk_i);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {addr_i, wdata_i, write_i, read_i, clear_watchdog_instr_i, sleep_instr_i} = '0;
    {sleep_active_i, clock_fail_i, internal_osc_freq_select_i, retention_regulator_cfg_i} = '0;
    {hw_watchdog_enable_cfg_i, watchdog_postscale_select_i} = '0;
    // longest tap keeps the mode sweep free of expiries
    watchdog_postscale_select_i = 5'h13;
    {regulator_enable_pin_i, ulp_wake_comparator_i, reset_i} = 3'h7;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'hb7);
    chk({6'h0, ulp_wake_enable_o, ulp_current_sink_o}, 8'h03);
    wr(2'h0, 8'h02);
    rd(2'h0, 8'h02);
    chk({7'h0, ulp_current_sink_o}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        hw_watchdog_enable_cfg_i <= m[1:0];
        sleep_active_i <= k[1];
        wr(2'h0, {7'h0, k[0]});
        exp_on = m == 3 || (m == 2 && k[0]) || (m == 1 && !k[1]);
        #1 chk({7'h0, low_freq_internal_osc_en_o}, {7'h0, exp_on});
        rd(2'h1, {6'h0, exp_on, 1'b0});
      end
    end
    wr(2'h0, 8'h80);
    #1 chk({6'h0, regulator_standby_o, regulator_ultra_low_o}, 8'h02);
    wr(2'h0, 8'h10);
    #1 chk({6'h0, regulator_standby_o, regulator_ultra_low_o}, 8'h01);
    retention_regulator_cfg_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({7'h0, regulator_ultra_low_o}, 8'h00);
    sleep_active_i <= 1'b0;
    watchdog_postscale_select_i <= 5'h00;
    clear_watchdog_instr_i <= 1'b1;
    @(posedge clk_i);
    clear_watchdog_instr_i <= 1'b0;
    wait_expiry(8, 1'b0);
    rd(2'h1, 8'h03);
    wr(2'h1, 8'h01);
    rd(2'h1, 8'h02);
    watchdog_postscale_select_i <= 5'h01;
    sleep_active_i <= 1'b1;
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    wait_expiry(16, 1'b1);
    rd(2'h1, 8'h03);
    test_done();
  end
  initial begin
    #100us;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
